// file: bench/vat_pipe_model.sv
// pipeline side model: issues one virtual address per command and
// checks that each answer comes exactly one cycle after its request.
// assumes the bench raises issue just after a rising edge of ref_clk.
`timescale 1ns/1ps
module vat_pipe_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // command from the bench
    input wire logic issue,
    input wire logic [63:0] issue_va,
    // request toward the translator
    output logic req_valid,
    output logic [63:0] req_va,
    // answer watch
    input wire logic rsp_valid,
    output logic lat_err
);
    logic [63:0] last_r;
    logic pend_r;
    // released address bus shows the inverse of the last value
    assign req_valid = issue;
    assign req_va = issue ? issue_va : ~last_r;
    // last address, pending answer and sticky latency fault
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            last_r <= 64'h0;
            pend_r <= 1'b0;
            lat_err <= 1'b0;
        end else begin
            pend_r <= issue;
            if (issue) begin
                last_r <= issue_va;
            end
            if (rsp_valid !== pend_r) begin
                lat_err <= 1'b1;
            end
        end
    end
endmodule

// file: bench/vat_translate_bench.sv
// self-checking bench for the virtual address translator: entry setup,
// user segment checks, tag matching, mode changes and shutdown.
// assumes vat_pkg, vat_translate and vat_pipe_model are compiled first.
`timescale 1ns/1ps
module vat_translate_bench;
    localparam logic [7:0] ST = vat_pkg::OFS_STATUS;
    localparam logic [7:0] HI = vat_pkg::OFS_ENTRY_HI;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic exc_return = 1'b0;
    logic issue = 1'b0;
    logic [63:0] issue_va = 64'h0;
    logic [63:0] req_va;
    logic [31:0] reg_rdata, rsp_pa;
    logic [2:0] rsp_cache;
    logic req_valid, rsp_valid, rsp_hit, rsp_tlb_miss, rsp_xtlb_miss;
    logic rsp_addr_err, rsp_outside, user_mode, lat_err;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    // ------------------------------------------------------------
    // clock, design and pipeline model
    // ------------------------------------------------------------
    always #25 ref_clk = ~ref_clk;
    vat_translate DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .req_valid(req_valid), .req_va(req_va), .exc_return(exc_return),
        .rsp_valid(rsp_valid), .rsp_hit(rsp_hit), .rsp_pa(rsp_pa), .rsp_cache(rsp_cache),
        .rsp_tlb_miss(rsp_tlb_miss), .rsp_xtlb_miss(rsp_xtlb_miss),
        .rsp_addr_err(rsp_addr_err), .rsp_outside(rsp_outside), .user_mode(user_mode));
    vat_pipe_model pipe (.ref_clk(ref_clk), .sys_rst(sys_rst), .issue(issue),
        .issue_va(issue_va), .req_valid(req_valid), .req_va(req_va),
        .rsp_valid(rsp_valid), .lat_err(lat_err));
    // ------------------------------------------------------------
    // compare and access tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_rsp(input logic [41:0] got, input logic [41:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: answer %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check_val(reg_rdata, exp);
    endtask
    task automatic set_entry(input logic [4:0] i, input logic [31:0] hi, input logic [7:0] ext,
        input logic [31:0] lo);
        reg_write(vat_pkg::OFS_INDEX, {27'h0, i});
        reg_write(HI, hi);
        reg_write(vat_pkg::OFS_ENTRY_HI_EXT, {24'h0, ext});
        reg_write(vat_pkg::OFS_ENTRY_LO, lo);
        reg_write(vat_pkg::OFS_TLB_WRITE, 32'h1);
    endtask
    // flags: tlb miss, wide miss, address error, outside
    task automatic translate(input logic [63:0] va, input logic hit, input logic [31:0] pa,
        input logic [2:0] cache, input logic [3:0] flg);
        @(posedge ref_clk);
        issue <= 1'b1;
        issue_va <= va;
        @(posedge ref_clk);
        issue <= 1'b0;
        #1;
        check_rsp({rsp_valid, rsp_hit, rsp_cache, rsp_tlb_miss, rsp_xtlb_miss, rsp_addr_err,
            rsp_outside, lat_err, rsp_pa}, {1'b1, hit, cache, flg, 1'b0, pa});
    endtask
    task automatic exception_return_instruction();
        @(posedge ref_clk);
        exc_return <= 1'b1;
        @(posedge ref_clk);
        exc_return <= 1'b0;
    endtask
    task automatic mode_is(input logic exp);
        repeat (2) @(posedge ref_clk);
        #1;
        check_val({31'h0, user_mode}, {31'h0, exp});
    endtask
    // ------------------------------------------------------------
    // hang guard
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        reg_read(ST, 32'h0000_0004);
        mode_is(1'b0);
        reg_read(8'h40, 32'h0);
        reg_read(vat_pkg::OFS_TLB_WRITE, 32'h0);
        set_entry(5'h00, 32'h0000_1411, 8'h00, 32'h04EA_AAAA);
        set_entry(5'h01, 32'h0004_0099, 8'h00, 32'h477F_FFFF);
        set_entry(5'h02, 32'hC000_0411, 8'hAB, 32'h0480_0001);
        set_entry(5'h04, 32'h0010_0011, 8'h00, 32'h2500_1234);
        reg_read(HI, 32'h0010_0011);
        reg_read(vat_pkg::OFS_ENTRY_LO, 32'h2500_1234);
        translate(64'h0000_0000_0000_17A3, 1'b1, 32'hAAAA_ABA3, 3'h3, 4'h0);
        translate(64'h0000_0000_0010_2ABC, 1'b1, 32'h0048_EABC, 3'h4, 4'h0);
        reg_write(ST, 32'h0000_0010);
        reg_read(ST, 32'h0000_0010);
        mode_is(1'b1);
        translate(64'h0000_0000_0000_17A3, 1'b1, 32'hAAAA_ABA3, 3'h3, 4'h0);
        translate(64'h0000_0000_0007_FFFF, 1'b1, 32'hFFFF_FFFF, 3'h5, 4'h0);
        translate(64'hFFFF_FFFF_8000_0000, 1'b0, 32'h0, 3'h0, 4'h2);
        reg_read(ST, 32'h0000_0012);
        mode_is(1'b0);
        exception_return_instruction();
        mode_is(1'b1);
        translate(64'h0000_0000_0000_2000, 1'b0, 32'h0, 3'h0, 4'h8);
        exception_return_instruction();
        reg_write(HI, 32'h0000_0022);
        translate(64'h0000_0000_0000_17A3, 1'b0, 32'h0, 3'h0, 4'h8);
        exception_return_instruction();
        translate(64'h0000_0000_0004_1234, 1'b1, 32'hFFFC_1234, 3'h5, 4'h0);
        reg_write(HI, 32'h0000_0011);
        reg_write(ST, 32'h0000_0030);
        translate(64'h0000_00AB_C000_04FF, 1'b1, 32'h0000_04FF, 3'h2, 4'h0);
        translate(64'h0000_0000_0004_1234, 1'b1, 32'hFFFC_1234, 3'h5, 4'h0);
        translate(64'h0000_0100_0000_0000, 1'b0, 32'h0, 3'h0, 4'h2);
        exception_return_instruction();
        translate(64'h0000_0012_0000_0000, 1'b0, 32'h0, 3'h0, 4'h4);
        exception_return_instruction();
        reg_write(ST, 32'h0000_0012);
        mode_is(1'b0);
        translate(64'hFFFF_FFFF_8000_0000, 1'b0, 32'h0, 3'h0, 4'h1);
        translate(64'h0000_0000_0000_17A3, 1'b1, 32'hAAAA_ABA3, 3'h3, 4'h0);
        set_entry(5'h03, 32'h0000_1411, 8'h00, 32'h04EA_AAAA);
        translate(64'h0000_0000_0000_17A3, 1'b0, 32'h0, 3'h0, 4'h8);
        reg_read(ST, 32'h0040_0012);
        translate(64'h0000_0000_0007_FFFF, 1'b0, 32'h0, 3'h0, 4'h8);
        @(posedge ref_clk);
        #1;
        check_val({31'h0, lat_err}, 32'h0);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        reg_read(ST, 32'h0000_0004);
        tally_and_finish();
    end
endmodule

// file: logic/vat_pkg.sv
// package for the virtual address translator: register map, field layout,
// reset values and page size constants.
// assumes a single 20 MHz core clock and a plain register port.
package vat_pkg;
    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int ENTRIES = 32;
    localparam int IDX_W = 5;
    localparam int PA_W = 32;
    localparam int TAG_W = 8;
    localparam int VPN_W = 30;
    localparam int PFN_W = 22;
    localparam int CACHE_W = 3;
    localparam int MIN_OFF = 10;
    localparam logic [2:0] SIZE_MAX = 3'h4;
    localparam logic [1:0] MODE_USER = 2'h2;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_ENTRY_HI = 8'h04;
    localparam logic [7:0] OFS_ENTRY_HI_EXT = 8'h08;
    localparam logic [7:0] OFS_ENTRY_LO = 8'h0C;
    localparam logic [7:0] OFS_INDEX = 8'h10;
    localparam logic [7:0] OFS_TLB_WRITE = 8'h14;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int ST_EXL = 1;
    localparam int ST_ERL = 2;
    localparam int ST_MODE_LO = 3;
    localparam int ST_UX = 5;
    localparam int ST_SHUTDOWN = 22;
    localparam int HI_VPN_LO = 10;
    localparam int LO_CACHE_LO = 22;
    localparam int LO_GLOBAL = 25;
    localparam int LO_VALID = 26;
    localparam int LO_SIZE_LO = 28;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic RST_ERL = 1'b1;
    localparam logic RST_EXL = 1'b0;
    localparam logic RST_UX = 1'b0;
endpackage

// file: logic/vat_translate.sv
// user segment check and tlb translation for the memory management unit.
// assumes the pipeline presents one virtual address per request on ref_clk
// and takes the registered answer in the next cycle.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

// Operation
// - physical addresses are 32 bits wide, a 4 gigabyte space.
// - entries carry an 8-bit address space tag from the entry high register.
// - hit needs equal page number and global bit or equal tag.
// - no matching entry raises a tlb mismatch exception.
// - physical address is entry page number joined with untranslated offset.
// - five page sizes, 1K to 256K, each four times the last.
// - 32-bit mode, 1K page: 10-bit offset, 22-bit page number.
// - 32-bit mode, 256K page: 18-bit offset, 14-bit page number.
// - 64-bit mode, 1K page: 10-bit offset, 30-bit page number.
// - 64-bit mode, 256K page: 18-bit offset, 22-bit page number.
// - exceptions enter kernel mode; exception return restores the earlier mode.
// - user mode only when mode field is 10 and both level bits 0.
// - user wide address bit picks narrow or wide user segment.
// - narrow segment holds addresses with bit 31 clear, 2 gigabytes.
// - wide segment holds addresses with bits 63 to 40 zero.
// - narrow user access with bit 31 set raises address error.
// - narrow segment miss uses the ordinary mismatch vector.
// - cacheability comes from the matching entry's cache field.
// - 32-bit addressing sign-extends bit 31 into bits 63 to 32.
// - user segments map through the tlb the same from every mode.
// - wide user access with any of bits 63 to 40 set raises address error.
// - wide segment miss uses the extended mismatch vector.
// - multiple matches set the shutdown flag; all later accesses miss until reset.
module vat_translate (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // pipeline request
    input wire logic req_valid,
    input wire logic [63:0] req_va,
    input wire logic exc_return,
    // translation answer
    output logic rsp_valid,
    output logic rsp_hit,
    output logic [31:0] rsp_pa,
    output logic [2:0] rsp_cache,
    output logic rsp_tlb_miss,
    output logic rsp_xtlb_miss,
    output logic rsp_addr_err,
    output logic rsp_outside,
    // mode state
    output logic user_mode
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [1:0] mode_r;
    logic exl_r;
    logic erl_r;
    logic ux_r;
    logic shutdown_r;
    logic [31:0] ent_hi_r;
    logic [7:0] ent_hi_ext_r;
    logic [31:0] ent_lo_r;
    logic [vat_pkg::IDX_W-1:0] index_r;
    logic [vat_pkg::VPN_W-1:0] tlb_vpn [vat_pkg::ENTRIES];
    logic [vat_pkg::TAG_W-1:0] tlb_tag [vat_pkg::ENTRIES];
    logic [vat_pkg::PFN_W-1:0] tlb_pfn [vat_pkg::ENTRIES];
    logic [vat_pkg::CACHE_W-1:0] tlb_cache [vat_pkg::ENTRIES];
    logic [2:0] tlb_size [vat_pkg::ENTRIES];
    logic [vat_pkg::ENTRIES-1:0] tlb_glb;
    logic [vat_pkg::ENTRIES-1:0] tlb_vld;
    logic [vat_pkg::ENTRIES-1:0] match_c;
    logic [63:0] addr_c;
    logic [7:0] cur_tag_c;
    logic user_c;
    logic seg_c;
    logic addr_err_c;
    logic multi_c;
    logic hit_c;
    logic miss_c;
    logic exc_c;
    logic [31:0] pa_c;
    logic [2:0] cache_c;
    logic [31:0] rdata_nxt;

    // offset mask for a size code: 10 + 2*code low bits pass untranslated, codes above 4 taken as 4
    function automatic logic [31:0] off_mask(input logic [2:0] sz);
        logic [2:0] s;
        s = (sz > vat_pkg::SIZE_MAX) ? vat_pkg::SIZE_MAX : sz;
        off_mask = (32'h0000_0400 << {s, 1'b0}) - 32'h0000_0001;
    endfunction

    // ----------------------------------------------------------------
    // address shaping and segment check
    // ----------------------------------------------------------------
    // mode decode and internal 64-bit address
    always_comb begin
        user_c = (mode_r == vat_pkg::MODE_USER) && !exl_r && !erl_r;
        cur_tag_c = ent_hi_r[7:0];
        addr_c = ux_r ? req_va : {{32{req_va[31]}}, req_va[31:0]};
        // same segment test whatever the mode
        seg_c = ux_r ? (addr_c[63:40] == 24'h00_0000) : !addr_c[31];
        addr_err_c = user_c && !seg_c;
    end

    // ----------------------------------------------------------------
    // per-entry compare
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < vat_pkg::ENTRIES; gi++) begin : g_ent
            logic [vat_pkg::VPN_W-1:0] vmask;
            // page bits under the offset do not take part
            assign vmask = ~(vat_pkg::VPN_W'(off_mask(tlb_size[gi]) >> vat_pkg::MIN_OFF));
            assign match_c[gi] = tlb_vld[gi]
                && (((addr_c[39:10] ^ tlb_vpn[gi]) & vmask) == '0)
                && (tlb_glb[gi] || (tlb_tag[gi] == cur_tag_c));
        end
    endgenerate

    // ----------------------------------------------------------------
    // hit select and physical address
    // ----------------------------------------------------------------
    always_comb begin
        logic [31:0] m;
        m = '0;
        pa_c = '0;
        cache_c = '0;
        for (int i = vat_pkg::ENTRIES - 1; i >= 0; i--) begin
            if (match_c[i]) begin
                m = off_mask(tlb_size[i]);
                // frame from the entry, offset straight from the address
                pa_c = ({tlb_pfn[i], 10'h000} & ~m) | (addr_c[31:0] & m);
                cache_c = tlb_cache[i];
            end
        end
        multi_c = |(match_c & (match_c - 1'b1));
        // shutdown or a double match forces a miss, whatever matched
        hit_c = seg_c && (|match_c) && !multi_c && !shutdown_r;
        miss_c = seg_c && !hit_c && !addr_err_c;
        exc_c = req_valid && (addr_err_c || miss_c);
    end

    // ----------------------------------------------------------------
    // answer registers, one cycle after the request
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rsp_valid <= 1'b0;
            rsp_hit <= 1'b0;
            rsp_pa <= '0;
            rsp_cache <= '0;
            rsp_tlb_miss <= 1'b0;
            rsp_xtlb_miss <= 1'b0;
            rsp_addr_err <= 1'b0;
            rsp_outside <= 1'b0;
        end else begin
            // every flag is gated by the request, so idle cycles answer all zero
            rsp_valid <= req_valid;
            rsp_hit <= req_valid && hit_c && !addr_err_c;
            rsp_pa <= (req_valid && hit_c) ? pa_c : '0;
            rsp_cache <= (req_valid && hit_c) ? cache_c : '0;
            rsp_tlb_miss <= req_valid && miss_c && !ux_r;
            rsp_xtlb_miss <= req_valid && miss_c && ux_r;
            rsp_addr_err <= req_valid && addr_err_c;
            // non-user reference outside user segments: left to other maps
            rsp_outside <= req_valid && !user_c && !seg_c;
        end
    end

    // ----------------------------------------------------------------
    // status: mode, level bits, shutdown
    // ----------------------------------------------------------------
    // exception sets the level bit; a same-cycle write or return loses
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mode_r <= vat_pkg::RST_MODE;
            exl_r <= vat_pkg::RST_EXL;
            erl_r <= vat_pkg::RST_ERL;
            ux_r <= vat_pkg::RST_UX;
        end else begin
            if (reg_wr && reg_addr == vat_pkg::OFS_STATUS) begin
                mode_r <= reg_wdata[vat_pkg::ST_MODE_LO +: 2];
                exl_r <= reg_wdata[vat_pkg::ST_EXL];
                erl_r <= reg_wdata[vat_pkg::ST_ERL];
                ux_r <= reg_wdata[vat_pkg::ST_UX];
            end else if (exc_return) begin
                // clear the outer level first; mode field untouched
                if (erl_r) begin
                    erl_r <= 1'b0;
                end else begin
                    exl_r <= 1'b0;
                end
            end
            if (exc_c) begin
                exl_r <= 1'b1;
            end
        end
    end

    // shutdown flag, cleared only by reset
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            shutdown_r <= 1'b0;
        end else if (req_valid && seg_c && multi_c) begin
            shutdown_r <= 1'b1;
        end
    end

    // registered user mode indication
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            user_mode <= 1'b0;
        end else begin
            user_mode <= user_c;
        end
    end

    // ----------------------------------------------------------------
    // staging registers and tlb write
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ent_hi_r <= '0;
            ent_hi_ext_r <= '0;
            ent_lo_r <= '0;
            index_r <= '0;
        end else if (reg_wr) begin
            if (reg_addr == vat_pkg::OFS_ENTRY_HI) begin
                ent_hi_r <= reg_wdata;
            end
            if (reg_addr == vat_pkg::OFS_ENTRY_HI_EXT) begin
                ent_hi_ext_r <= reg_wdata[7:0];
            end
            if (reg_addr == vat_pkg::OFS_ENTRY_LO) begin
                ent_lo_r <= reg_wdata;
            end
            if (reg_addr == vat_pkg::OFS_INDEX) begin
                index_r <= reg_wdata[vat_pkg::IDX_W-1:0];
            end
        end
    end

    // entry array; valid and global bits reset, other contents kept
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tlb_vld <= '0;
            tlb_glb <= '0;
        end else if (reg_wr && reg_addr == vat_pkg::OFS_TLB_WRITE) begin
            tlb_vld[index_r] <= ent_lo_r[vat_pkg::LO_VALID];
            tlb_glb[index_r] <= ent_lo_r[vat_pkg::LO_GLOBAL];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reg_wr && reg_addr == vat_pkg::OFS_TLB_WRITE) begin
            tlb_vpn[index_r] <= {ent_hi_ext_r, ent_hi_r[31:vat_pkg::HI_VPN_LO]};
            tlb_tag[index_r] <= ent_hi_r[7:0];
            tlb_pfn[index_r] <= ent_lo_r[vat_pkg::PFN_W-1:0];
            tlb_cache[index_r] <= ent_lo_r[vat_pkg::LO_CACHE_LO +: 3];
            tlb_size[index_r] <= ent_lo_r[vat_pkg::LO_SIZE_LO +: 3];
        end
    end

    // ----------------------------------------------------------------
    // read back
    // ----------------------------------------------------------------
    always_comb begin
        rdata_nxt = '0;
        unique case (reg_addr)
            vat_pkg::OFS_STATUS: begin
                rdata_nxt[vat_pkg::ST_EXL] = exl_r;
                rdata_nxt[vat_pkg::ST_ERL] = erl_r;
                rdata_nxt[vat_pkg::ST_MODE_LO +: 2] = mode_r;
                rdata_nxt[vat_pkg::ST_UX] = ux_r;
                rdata_nxt[vat_pkg::ST_SHUTDOWN] = shutdown_r;
            end
            vat_pkg::OFS_ENTRY_HI: rdata_nxt = ent_hi_r;
            vat_pkg::OFS_ENTRY_HI_EXT: rdata_nxt[7:0] = ent_hi_ext_r;
            vat_pkg::OFS_ENTRY_LO: rdata_nxt = ent_lo_r;
            vat_pkg::OFS_INDEX: rdata_nxt[vat_pkg::IDX_W-1:0] = index_r;
            default: rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rdata_nxt : '0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    AST_RSP_NEXT: assert property (req_valid |=> rsp_valid)
        else $error("answer missing one cycle after request");
    AST_NO_RSP: assert property (!req_valid |=> !rsp_valid)
        else $error("answer without request");
    AST_OFFSET_PASS: assert property (rsp_hit |-> rsp_pa[9:0] == $past(req_va[9:0]))
        else $error("offset bits altered");
    AST_MISS_VECTOR: assert property (rsp_valid && !rsp_hit && !rsp_addr_err && !rsp_outside
        |-> (rsp_tlb_miss ^ rsp_xtlb_miss))
        else $error("miss without exactly one mismatch vector");
    AST_NARROW_ERR: assert property (req_valid && user_c && !ux_r && req_va[31]
        |=> rsp_addr_err && !rsp_hit && !rsp_tlb_miss)
        else $error("narrow user address error not raised");
    AST_WIDE_ERR: assert property (req_valid && user_c && ux_r && req_va[63:40] != 24'h00_0000
        |=> rsp_addr_err && !rsp_xtlb_miss)
        else $error("wide user address error not raised");
    AST_SHUT_STICKY: assert property (shutdown_r |=> shutdown_r)
        else $error("shutdown flag cleared without reset");
    AST_SHUT_MISS: assert property (shutdown_r && req_valid |=> !rsp_hit)
        else $error("hit while shut down");
    AST_EXC_KERNEL: assert property ((rsp_addr_err || rsp_tlb_miss || rsp_xtlb_miss)
        |-> exl_r ##1 !user_mode)
        else $error("exception did not enter kernel mode");
    AST_XMISS_WIDE: assert property (rsp_xtlb_miss |-> $past(ux_r))
        else $error("extended vector used for narrow segment");
    AST_USER_DECODE: assert property (user_mode == $past(mode_r == vat_pkg::MODE_USER
        && !exl_r && !erl_r))
        else $error("user mode decode wrong");

    // answer shape: one outcome per answer, nothing between answers
    AST_ONE_ANSWER: assert property (rsp_valid |-> $onehot({rsp_hit, rsp_tlb_miss, rsp_xtlb_miss,
        rsp_addr_err, rsp_outside}))
        else $error("answer without exactly one outcome");
    AST_IDLE_QUIET: assert property (!rsp_valid |-> !(rsp_hit || rsp_tlb_miss || rsp_xtlb_miss
        || rsp_addr_err || rsp_outside) && rsp_pa == '0)
        else $error("answer flags without a request");
    AST_MISS_ZERO: assert property (rsp_valid && !rsp_hit |-> rsp_pa == '0 && rsp_cache == '0)
        else $error("address or cache field shown without a hit");

    // exception level entry and return
    AST_EXC_SETS: assert property (exc_c |=> exl_r)
        else $error("exception did not set the exception level");
    AST_RET_CLEARS: assert property (exc_return && !exc_c && !erl_r && exl_r
        && !(reg_wr && reg_addr == vat_pkg::OFS_STATUS) |=> !exl_r)
        else $error("exception return left the exception level set");
    AST_RET_MODE: assert property (exc_return && !(reg_wr && reg_addr == vat_pkg::OFS_STATUS)
        |=> $stable(mode_r) && $stable(ux_r))
        else $error("exception return changed the mode field");

    // shutdown and segment decode
    AST_SHUT_SET: assert property (req_valid && seg_c && multi_c |=> shutdown_r)
        else $error("multiple match did not set the shutdown flag");
    AST_KERNEL_NO_ERR: assert property (req_valid && !user_c |=> !rsp_addr_err)
        else $error("address error outside user mode");
    AST_MISS_NARROW: assert property (rsp_tlb_miss |-> !$past(ux_r))
        else $error("ordinary vector used for wide segment");
    AST_NARROW_MAP: assert property (req_valid && user_c && !ux_r && !req_va[31]
        |=> !rsp_addr_err && !rsp_xtlb_miss)
        else $error("narrow user address refused");
    AST_WIDE_MAP: assert property (req_valid && user_c && ux_r && req_va[63:40] == 24'h00_0000
        |=> !rsp_addr_err && !rsp_tlb_miss)
        else $error("wide user address refused");

    // main scenarios
    COV_HIT: cover property (req_valid && user_c ##1 rsp_hit);
    COV_MISS: cover property (rsp_tlb_miss ##1 exc_return);
    COV_ADDR_ERR: cover property (rsp_addr_err);
    COV_SHUTDOWN: cover property (!shutdown_r ##1 shutdown_r);
    COV_WIDE_MISS: cover property (rsp_xtlb_miss);
endmodule
